// ---- wit_pkg.sv ----
package wit_pkg;
  // bus geometry: printed offsets are word indices, byte address is four times that
  localparam int          WIT_ADR_W      = 18;
  localparam int          WIT_IDX_W      = 16;
  localparam logic [15:0] WIT_IDX_OVF    = 16'hFF42;
  localparam logic [15:0] WIT_IDX_MODE   = 16'hFFF9;
  localparam logic [15:0] WIT_IDX_SETTLE = 16'hFFFA;
  localparam logic [15:0] WIT_IDX_CTRL   = 16'hFFF0;
  localparam logic [15:0] WIT_IDX_STAT   = 16'hFFF1;

  // field positions
  localparam int WIT_CODE_W   = 3;
  localparam int WIT_RUN_BIT  = 7;
  localparam int WIT_MODE_BIT = 4;
  localparam int WIT_RSEL_BIT = 3;
  localparam int WIT_MSK_BIT  = 0;
  localparam int WIT_PRI_BIT  = 1;
  localparam int WIT_ST_REQ   = 0;
  localparam int WIT_ST_BUSY  = 1;
  localparam int WIT_ST_RUN   = 2;

  // reset values and settle code limit
  localparam logic [7:0] WIT_OVF_RST    = 8'h00;
  localparam logic [7:0] WIT_MODE_RST   = 8'h00;
  localparam logic [7:0] WIT_SETTLE_RST = 8'h04;
  localparam logic [7:0] WIT_CTRL_RST   = 8'h03;
  localparam logic [2:0] WIT_SETTLE_MAX = 3'h4;

  // counter structure: 8-bit prescaler feeding an upper counter
  localparam int WIT_PRE_W = 8;
  localparam int WIT_UP_W  = 12;
  localparam int WIT_STL_W = 18;

  // power-of-two exponents per select code
  localparam int WIT_OVF_EXP [8] = '{12, 13, 14, 15, 16, 17, 18, 20};
  localparam int WIT_STL_EXP [8] = '{12, 14, 15, 16, 17, 17, 17, 17};

  typedef enum {WIT_INTERVAL, WIT_GUARD_NMI, WIT_GUARD_RST} wit_mode_t;
endpackage

// ---- wit_core_if.sv ----
`timescale 1ns/1ns
interface wit_core_if;
  // overflow counter group
  logic       clear;
  logic       clk_on;
  logic       run;
  logic [2:0] ovf_code;
  logic       ovf;
  // oscillation settle group
  logic       stl_start;
  logic [2:0] stl_code;
  logic       stl_busy;

  modport top_mp (output clear, clk_on, run, ovf_code, stl_start, stl_code,
                  input ovf, stl_busy);
  modport ctr_mp (input clear, clk_on, run, ovf_code, output ovf);
  modport stl_mp (input stl_start, stl_code, output stl_busy);
endinterface

// ---- wit_counter.sv ----
`timescale 1ns/1ns
module wit_counter
  import wit_pkg::*;
#(
  parameter int TRIM = 0
)(
  // clock and reset
  input  wire logic  clk_sys_in,
  input  wire logic  rst_b_in,
  // core group
  wit_core_if.ctr_mp c
);
  logic [WIT_PRE_W-1:0] pre_ff;
  logic [WIT_UP_W-1:0]  up_ff;
  logic [WIT_UP_W-1:0]  up_tgt;
  logic                 pre_tick;

  // last upper value before wrap for the selected timeout
  assign up_tgt   = WIT_UP_W'((1 << (WIT_OVF_EXP[c.ovf_code] - TRIM - WIT_PRE_W)) - 1);
  assign pre_tick = c.clk_on && (pre_ff == '1);
  assign c.ovf    = c.run && pre_tick && (up_ff == up_tgt); // RULE4

  // prescaler runs free while the clock runs, a clear never touches it
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      pre_ff <= '0;
    else if (c.clk_on) // RULE21
      pre_ff <= pre_ff + 1'b1;
  end

  // upper counter: early first timeout comes from the untouched prescaler
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      up_ff <= '0;
    else if (c.clear) // RULE5 RULE10
      up_ff <= '0;
    else if (c.run && pre_tick) // RULE8 RULE11
      up_ff <= (up_ff == up_tgt) ? '0 : up_ff + 1'b1;
  end

  clear_zero_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE5
    c.clear |=> up_ff == '0)
    else $error("upper counter not cleared by run write");
  freeze_stop_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE8
    !c.clk_on && !c.clear |=> $stable(up_ff) && $stable(pre_ff))
    else $error("counter moved while clock stopped");
  pre_free_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE21
    c.clear && c.clk_on |=> pre_ff == WIT_PRE_W'($past(pre_ff) + 1'b1))
    else $error("prescaler disturbed by clear");
endmodule // wit_counter

// ---- wit_settle.sv ----
`timescale 1ns/1ns
module wit_settle
  import wit_pkg::*;
#(
  parameter int TRIM = 0
)(
  // clock and reset
  input  wire logic  clk_sys_in,
  input  wire logic  rst_b_in,
  // core group
  wit_core_if.stl_mp s
);
  logic [WIT_STL_W-1:0] cnt_ff;
  logic [WIT_STL_W-1:0] tgt;
  logic                 busy_ff;

  assign tgt        = WIT_STL_W'((1 << (WIT_STL_EXP[s.stl_code] - TRIM)) - 1);
  assign s.stl_busy = busy_ff;

  // busy from reset: the reset value of the select gives the long wait
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      busy_ff <= 1'b1; // RULE1
      cnt_ff  <= '0;
    end
    else if (s.stl_start)
    begin
      busy_ff <= 1'b1;
      cnt_ff  <= '0;
    end
    else if (busy_ff)
    begin
      busy_ff <= (cnt_ff != tgt); // RULE2
      cnt_ff  <= cnt_ff + 1'b1;
    end
  end
endmodule // wit_settle

// ---- wit_top.sv ----
`timescale 1ns/1ns
// Overview of operation
// RULE1 - reset loads settle select with default, giving a 2^17 period wait
// RULE2 - settle codes 0..4 pick 2^12,14,15,16,17 periods; others are refused
// RULE3 - mode select bit four set makes the block a runaway watchdog
// RULE4 - overflow code picks 2^12..2^18 periods, code seven gives 2^20
// RULE5 - first run write starts counting, later run writes clear and restart
// RULE6 - unserviced overflow gives reset or nmi, chosen by reset select bit
// RULE7 - software rewrites run bit before every timeout once running
// RULE8 - counting goes on during halt and freezes during stop
// RULE9 - software writes run bit just before entering stop
// RULE10 - first timeout after a clear may be up to 2^8 periods early
// RULE11 - counting pauses while the cpu runs from the subsystem clock
// RULE12 - mode bit clear gives interval timer, request at each interval
// RULE13 - interval counting starts on a run bit write of one
// RULE14 - interval request is gated by the mask flag, carries priority flag
// RULE15 - interval request holds highest default rank among maskable sources
// RULE16 - once watchdog mode is chosen, interval mode returns only by reset
// RULE17 - first interval after mode write may be up to 2^8 periods short
// RULE18 - run bit ignores writes of zero, only reset stops counting
// RULE19 - mode and reset select bits are set-only until reset
// RULE20 - reset clears overflow select and mode register, timer stopped
// RULE21 - free 8-bit prescaler feeds upper counter, run write clears upper only
module wit_top
  import wit_pkg::*;
#(
  parameter int TRIM = 0
)(
  // clock and reset
  input  wire logic                 clk_sys_in,
  input  wire logic                 rst_b_in,
  // wishbone slave
  input  wire logic                 wb_cyc_in,
  input  wire logic                 wb_stb_in,
  input  wire logic                 wb_we_in,
  input  wire logic [WIT_ADR_W-1:0] wb_adr_in,
  input  wire logic [3:0]           wb_sel_in,
  input  wire logic [31:0]          wb_dat_in,
  output logic      [31:0]          wb_dat_out,
  output logic                      wb_ack_out,
  // power state from the cpu core
  input  wire logic                 stop_mode_in,
  input  wire logic                 stop_release_in,
  input  wire logic                 subclk_sel_in,
  // overflow actions and settle busy
  output logic                      nmi_out,
  output logic                      sys_reset_out,
  output logic                      interval_irq_request_out,
  output logic                      interval_irq_priority_out,
  output logic                      osc_settle_busy_out
);
  // shortest interval must still span more than the prescaler
  if (TRIM < 0 || TRIM > WIT_OVF_EXP[0] - WIT_PRE_W - 1)
    $error("TRIM out of range for the prescaler width");

  wit_core_if cif ();

  // bus handshake terms
  logic                 bus_req;
  logic                 bus_wr;
  logic                 bus_rd;
  logic [WIT_IDX_W-1:0] bus_idx;
  logic [7:0]           wdat;
  logic                 hit_ovf;
  logic                 hit_mode;
  logic                 hit_settle;
  logic                 hit_ctrl;
  logic                 hit_stat;
  logic                 ack_ff;
  logic [31:0]          rdat_ff;
  logic [31:0]          nxt_rdat;

  // register state
  logic [2:0]           ovf_code_ff;
  logic                 run_ff;
  logic                 mode_sel_ff;
  logic                 rsel_ff;
  logic [2:0]           settle_code_ff;
  logic                 mask_ff;
  logic                 pri_ff;
  logic                 req_flag_ff;
  logic                 nmi_ff;
  logic                 rst_ff;
  logic                 settle_ok;
  wit_mode_t            cur_mode;

  // one word per register, data in the low byte lane
  assign bus_req    = wb_cyc_in && wb_stb_in && !ack_ff;
  assign bus_wr     = bus_req && wb_we_in && wb_sel_in[0];
  assign bus_rd     = bus_req && !wb_we_in;
  assign bus_idx    = wb_adr_in[WIT_ADR_W-1:2];
  assign wdat       = wb_dat_in[7:0];
  assign hit_ovf    = (bus_idx == WIT_IDX_OVF);
  assign hit_mode   = (bus_idx == WIT_IDX_MODE);
  assign hit_settle = (bus_idx == WIT_IDX_SETTLE);
  assign hit_ctrl   = (bus_idx == WIT_IDX_CTRL);
  assign hit_stat   = (bus_idx == WIT_IDX_STAT);

  // ack one cycle after the strobe, dropped the cycle after
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ack_ff <= 1'b0;
    else
      ack_ff <= bus_req;
  end

  // read mux; unmapped words read as zero and still ack
  always_comb
  begin
    nxt_rdat = '0;
    if (hit_ovf)
      nxt_rdat[WIT_CODE_W-1:0] = ovf_code_ff;
    else if (hit_mode)
    begin
      nxt_rdat[WIT_RUN_BIT]  = run_ff;
      nxt_rdat[WIT_MODE_BIT] = mode_sel_ff;
      nxt_rdat[WIT_RSEL_BIT] = rsel_ff;
    end
    else if (hit_settle)
      nxt_rdat[WIT_CODE_W-1:0] = settle_code_ff;
    else if (hit_ctrl)
    begin
      nxt_rdat[WIT_MSK_BIT] = mask_ff;
      nxt_rdat[WIT_PRI_BIT] = pri_ff;
    end
    else if (hit_stat)
    begin
      nxt_rdat[WIT_ST_REQ]  = req_flag_ff;
      nxt_rdat[WIT_ST_BUSY] = cif.stl_busy;
      nxt_rdat[WIT_ST_RUN]  = run_ff;
    end
  end

  // read data captured with the ack, held otherwise
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      rdat_ff <= '0;
    else if (bus_rd)
      rdat_ff <= nxt_rdat;
  end

  assign wb_ack_out = ack_ff;
  assign wb_dat_out = rdat_ff;

  // overflow time select, plain read/write
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ovf_code_ff <= WIT_OVF_RST[WIT_CODE_W-1:0]; // RULE20
    else if (bus_wr && hit_ovf)
      ovf_code_ff <= wdat[WIT_CODE_W-1:0]; // RULE4
  end

  // run bit: a zero write is ignored so counting only stops at reset
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      run_ff <= WIT_MODE_RST[WIT_RUN_BIT]; // RULE20
    else if (bus_wr && hit_mode && wdat[WIT_RUN_BIT]) // RULE13 RULE18
      run_ff <= 1'b1;
  end

  // mode and reset select are set-only
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mode_sel_ff <= WIT_MODE_RST[WIT_MODE_BIT]; // RULE20
      rsel_ff     <= WIT_MODE_RST[WIT_RSEL_BIT];
    end
    else if (bus_wr && hit_mode)
    begin
      mode_sel_ff <= mode_sel_ff | wdat[WIT_MODE_BIT]; // RULE16 RULE19
      rsel_ff     <= rsel_ff | wdat[WIT_RSEL_BIT]; // RULE19
    end
  end

  // forbidden settle codes leave the old selection in place
  assign settle_ok = (wdat[WIT_CODE_W-1:0] <= WIT_SETTLE_MAX);

  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      settle_code_ff <= WIT_SETTLE_RST[WIT_CODE_W-1:0]; // RULE1
    else if (bus_wr && hit_settle && settle_ok) // RULE2
      settle_code_ff <= wdat[WIT_CODE_W-1:0];
  end

  // mask and priority flags of the interval request
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      mask_ff <= WIT_CTRL_RST[WIT_MSK_BIT];
      pri_ff  <= WIT_CTRL_RST[WIT_PRI_BIT];
    end
    else if (bus_wr && hit_ctrl)
    begin
      mask_ff <= wdat[WIT_MSK_BIT];
      pri_ff  <= wdat[WIT_PRI_BIT];
    end
  end

  // overflow action follows mode and reset select
  always_comb
  begin
    if (!mode_sel_ff)
      cur_mode = WIT_INTERVAL; // RULE12
    else if (rsel_ff)
      cur_mode = WIT_GUARD_RST; // RULE3
    else
      cur_mode = WIT_GUARD_NMI; // RULE3
  end

  // core signals to the counter and the settle timer
  // halt needs no term: the counter simply keeps running through it
  assign cif.clear     = bus_wr && hit_mode && wdat[WIT_RUN_BIT]; // RULE5 RULE17
  assign cif.clk_on    = !stop_mode_in && !subclk_sel_in && !cif.stl_busy; // RULE8 RULE11
  assign cif.run       = run_ff;
  assign cif.ovf_code  = ovf_code_ff;
  assign cif.stl_start = stop_release_in;
  assign cif.stl_code  = settle_code_ff;

  // interval flag: an overflow in the clearing cycle wins over the clear
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      req_flag_ff <= 1'b0;
    else if (cif.ovf && cur_mode == WIT_INTERVAL) // RULE12
      req_flag_ff <= 1'b1;
    else if (bus_wr && hit_stat && wdat[WIT_ST_REQ])
      req_flag_ff <= 1'b0;
  end

  // one-cycle action pulses from flops
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      nmi_ff <= 1'b0;
      rst_ff <= 1'b0;
    end
    else
    begin
      nmi_ff <= cif.ovf && (cur_mode == WIT_GUARD_NMI); // RULE6
      rst_ff <= cif.ovf && (cur_mode == WIT_GUARD_RST); // RULE6
    end
  end

  assign nmi_out                   = nmi_ff;
  assign sys_reset_out             = rst_ff;
  // sits on the top-ranked maskable slot of the interrupt controller
  assign interval_irq_request_out  = req_flag_ff && !mask_ff; // RULE14 RULE15
  assign interval_irq_priority_out = pri_ff; // RULE14
  assign osc_settle_busy_out       = cif.stl_busy;

  wit_counter #(
    .TRIM       (TRIM)
  ) u_counter (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .c          (cif.ctr_mp)
  );

  wit_settle #(
    .TRIM       (TRIM)
  ) u_settle (
    .clk_sys_in (clk_sys_in),
    .rst_b_in   (rst_b_in),
    .s          (cif.stl_mp)
  );

  settle_dflt_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE1
    $rose(rst_b_in) |-> settle_code_ff == WIT_SETTLE_RST[2:0] && cif.stl_busy)
    else $error("settle select or busy wrong after reset");

  settle_refuse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE2
    bus_wr && hit_settle && !settle_ok |=> $stable(settle_code_ff))
    else $error("forbidden settle code accepted");

  nmi_cause_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE6
    nmi_out |-> $past(cif.ovf) && $past(mode_sel_ff) && !$past(rsel_ff) && !sys_reset_out)
    else $error("nmi without watchdog overflow");

  rst_cause_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE6
    $past(cif.ovf) && $past(mode_sel_ff) && $past(rsel_ff) |-> sys_reset_out ##1 !sys_reset_out)
    else $error("watchdog reset pulse missing");

  interval_set_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE12
    cif.ovf && !mode_sel_ff |=> req_flag_ff && !nmi_out && !sys_reset_out)
    else $error("interval overflow lost");

  stopped_idle_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE13
    !run_ff |-> !cif.ovf && !req_flag_ff && !nmi_out && !sys_reset_out)
    else $error("overflow before run");

  irq_mask_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE14
    bus_wr && hit_ctrl && wdat[WIT_MSK_BIT] |=> !interval_irq_request_out)
    else $error("masked interval request shown");

  mode_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE16
    mode_sel_ff |=> mode_sel_ff)
    else $error("watchdog mode left without reset");

  run_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE18
    run_ff |=> run_ff [*2])
    else $error("run bit cleared by software");

  subclk_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE11
    subclk_sel_in |=> !nmi_out && !sys_reset_out && !$rose(req_flag_ff))
    else $error("counting on subsystem clock");

  run_start_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE13
    bus_wr && hit_mode && wdat[WIT_RUN_BIT] |=> run_ff)
    else $error("run write did not start counting");

  rsel_sticky_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE19
    rsel_ff |=> rsel_ff)
    else $error("reset select cleared without reset");

  settle_take_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE2
    bus_wr && hit_settle && settle_ok |=> settle_code_ff == $past(wdat[WIT_CODE_W-1:0]))
    else $error("legal settle code not stored");

  nmi_pulse_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE6
    nmi_out |=> !nmi_out)
    else $error("nmi longer than one cycle");

  guard_action_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE3
    cif.ovf && mode_sel_ff |=> !$rose(req_flag_ff) && (nmi_out || sys_reset_out))
    else $error("watchdog overflow without its action");

  pri_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE14
    bus_wr && hit_ctrl |=> interval_irq_priority_out == $past(wdat[WIT_PRI_BIT]))
    else $error("priority flag not taken from write");

  stop_hold_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE8
    stop_mode_in |=> !nmi_out && !sys_reset_out && !$rose(req_flag_ff))
    else $error("overflow action during stop");

  ovf_write_a: assert property (@(posedge clk_sys_in) disable iff (!rst_b_in) // RULE4
    bus_wr && hit_ovf |=> ovf_code_ff == $past(wdat[WIT_CODE_W-1:0]))
    else $error("overflow code not stored");
endmodule // wit_top

// ---- wit_cpu_model.sv ----
`timescale 1ns/1ns
module wit_cpu_model
(
  // clock and reset
  input  wire logic clk_sys_in,
  input  wire logic rst_b_in,
  // requests from the timer
  input  wire logic nmi_in,
  input  wire logic sys_reset_in,
  input  wire logic irq_req_in,
  // event log
  output int        now_out,
  output int        n_irq_out,
  output int        n_nmi_out,
  output int        n_rst_out,
  output int        t_irq_out,
  output int        t_nmi_out
);
  logic irq_d_ff;

  // free cycle count, kept through resets so stamps stay comparable
  always_ff @(posedge clk_sys_in)
  begin
    now_out <= now_out + 1;
  end

  // controller logs each irq and nmi request with its cycle, reset requests are only counted
  always_ff @(posedge clk_sys_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      irq_d_ff <= 1'b0;
    end
    else
    begin
      irq_d_ff <= irq_req_in;
      if (irq_req_in && !irq_d_ff)
      begin
        n_irq_out <= n_irq_out + 1;
        t_irq_out <= now_out;
      end
      if (nmi_in)
      begin
        n_nmi_out <= n_nmi_out + 1;
        t_nmi_out <= now_out;
      end
      if (sys_reset_in)
      begin
        n_rst_out <= n_rst_out + 1;
      end
    end
  end
endmodule // wit_cpu_model

// ---- wit_top_tb_top.sv ----
`timescale 1ns/1ns
module wit_top_tb_top;
  import wit_pkg::*;
  localparam int T = 3;
  logic        clk    = 1'b0;
  logic        rst_b  = 1'b0;
  logic        cyc    = 1'b0;
  logic        stb    = 1'b0;
  logic        we     = 1'b0;
  logic [17:0] adr    = 18'h00000;
  logic [31:0] wdat   = 32'h00000000;
  logic        stop   = 1'b0;
  logic        rel    = 1'b0;
  logic        subclk = 1'b0;
  logic [31:0] rdat;
  logic        ack, nmi, srst, irq, pri, busy;
  logic [7:0]  rd;
  logic [15:0] idx_t [5];
  logic [7:0]  exp_t [5];
  int          now, n_irq, n_nmi, n_rst, t_irq, t_nmi;
  int          n_mismatch = 0;
  int          checked    = 0;
  int          p, t0, k, h, c;

  // 125 MHz system clock
  always #4 clk = ~clk;

  wit_top #(.TRIM(T)) dut (
    .clk_sys_in(clk), .rst_b_in(rst_b), .wb_cyc_in(cyc), .wb_stb_in(stb),
    .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(4'h1), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .stop_mode_in(stop),
    .stop_release_in(rel), .subclk_sel_in(subclk), .nmi_out(nmi),
    .sys_reset_out(srst), .interval_irq_request_out(irq),
    .interval_irq_priority_out(pri), .osc_settle_busy_out(busy));

  wit_cpu_model cpu (
    .clk_sys_in(clk), .rst_b_in(rst_b), .nmi_in(nmi), .sys_reset_in(srst),
    .irq_req_in(irq), .now_out(now), .n_irq_out(n_irq), .n_nmi_out(n_nmi),
    .n_rst_out(n_rst), .t_irq_out(t_irq), .t_nmi_out(t_nmi));

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic fail(input string m);
    n_mismatch++;
    $display("[ERR] %0t %s", $time, m);
  endtask

  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    checked++;
    if (g !== e)
      fail(m);
  endtask

  task automatic chk1(input logic g, input logic e, input string m);
    checked++;
    if (g !== e)
      fail(m);
  endtask

  task automatic chkr(input int g, input int lo, input int hi, input string m);
    checked++;
    if (g < lo || g > hi)
      fail(m);
  endtask

  function automatic int ovf_exp(input int cd);
    return (cd == 7) ? 20 : cd + 12;
  endfunction

  // one classic cycle; entered and left just after a rising edge
  task automatic bus(input logic w, input logic [15:0] ix, input logic [7:0] d);
    int i;
    i = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {ix, 2'b00};
    wdat <= {24'h000000, d};
    do
    begin
      @(posedge clk);
      i++;
    end
    while (ack !== 1'b1 && i < 20);
    if (i >= 20)
    begin
      fail("bus ack missing");
      wrap_up();
    end
    rd = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk);
  endtask

  function automatic int cnt(input int kind);
    return (kind == 0) ? n_irq : (kind == 1) ? n_nmi : n_rst;
  endfunction

  task automatic wait_ev(input int kind, input int lim);
    int c0, i;
    c0 = cnt(kind);
    i = 0;
    while (cnt(kind) == c0 && i < lim)
    begin
      @(posedge clk);
      i++;
    end
    if (i >= lim)
    begin
      fail("event missing");
      wrap_up();
    end
  endtask

  // settle busy length counted on falling edges where busy is still high
  task automatic settle_len(input int e);
    int i;
    i = 0;
    @(negedge clk);
    while (busy === 1'b1 && i < 70000)
    begin
      @(negedge clk);
      i++;
    end
    chkr(i, 2 ** (e - T) - 1, 2 ** (e - T) + 2, "settle length");
    @(posedge clk);
  endtask

  initial
  begin
    void'($urandom(30));
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    settle_len(17);
    idx_t = '{WIT_IDX_OVF, WIT_IDX_MODE, WIT_IDX_SETTLE, WIT_IDX_CTRL, 16'h0123};
    exp_t = '{8'h00, 8'h00, 8'h04, 8'h03, 8'h00};
    for (k = 0; k < 5; k++)
    begin
      bus(1'b0, idx_t[k], 8'h00);
      chk8(rd, exp_t[k], "reset value");
    end
    $display("test reset done");
    // every settle code, then refused codes keep the old one
    for (k = 0; k < 5; k++)
    begin
      bus(1'b1, WIT_IDX_SETTLE, 8'(k));
      rel <= 1'b1;
      @(posedge clk);
      rel <= 1'b0;
      settle_len((k == 0) ? 12 : k + 13);
    end
    for (k = 5; k < 8; k++)
    begin
      bus(1'b1, WIT_IDX_SETTLE, 8'(k));
      bus(1'b0, WIT_IDX_SETTLE, 8'h00);
      chk8(rd, 8'h04, "refused settle code");
    end
    bus(1'b1, WIT_IDX_OVF, 8'hFF);
    bus(1'b0, WIT_IDX_OVF, 8'h00);
    chk8(rd, 8'h07, "overflow code field");
    $display("test settle done");
    // interval mode, first and steady period
    c = $urandom_range(2, 0);
    p = 2 ** (ovf_exp(c) - T);
    bus(1'b1, WIT_IDX_OVF, 8'(c));
    bus(1'b1, WIT_IDX_CTRL, 8'h00);
    chk1(pri, 1'b0, "priority low");
    t0 = now;
    bus(1'b1, WIT_IDX_MODE, 8'h80);
    wait_ev(0, p + 10);
    chkr(t_irq - t0, p - 258, p + 6, "first interval");
    bus(1'b1, WIT_IDX_STAT, 8'h01);
    chk1(irq, 1'b0, "flag cleared");
    t0 = t_irq;
    wait_ev(0, p + 10);
    chkr(t_irq - t0, p, p, "interval period");
    // masked request is held back, flag still set
    bus(1'b1, WIT_IDX_CTRL, 8'h03);
    chk1(pri, 1'b1, "priority high");
    bus(1'b1, WIT_IDX_STAT, 8'h01);
    repeat (p + 20) @(posedge clk);
    chk1(irq, 1'b0, "masked request");
    bus(1'b0, WIT_IDX_STAT, 8'h00);
    chk1(rd[0], 1'b1, "flag under mask");
    bus(1'b1, WIT_IDX_CTRL, 8'h00);
    chk1(irq, 1'b1, "unmasked request");
    bus(1'b1, WIT_IDX_MODE, 8'h00);
    bus(1'b0, WIT_IDX_MODE, 8'h00);
    chk8(rd, 8'h80, "run kept");
    $display("test interval done");
    // stop and subsystem clock freeze the count
    bus(1'b1, WIT_IDX_STAT, 8'h01);
    wait_ev(0, p + 10);
    t0 = t_irq;
    bus(1'b1, WIT_IDX_STAT, 8'h01);
    h = $urandom_range(60, 1);
    stop <= 1'b1;
    repeat (h) @(posedge clk);
    stop <= 1'b0;
    subclk <= 1'b1;
    repeat (30) @(posedge clk);
    subclk <= 1'b0;
    wait_ev(0, p + 100);
    chkr(t_irq - t0, p + h + 30, p + h + 30, "frozen period");
    $display("test freeze done");
    // watchdog serviced, then left to run out
    bus(1'b1, WIT_IDX_STAT, 8'h01);
    c = n_nmi;
    bus(1'b1, WIT_IDX_MODE, 8'h90);
    for (k = 0; k < 6; k++)
    begin
      repeat ($urandom_range(p / 4, 64)) @(posedge clk);
      bus(1'b1, WIT_IDX_MODE, 8'h90);
    end
    chkr(n_nmi, c, c, "no nmi while serviced");
    t0 = now;
    bus(1'b1, WIT_IDX_MODE, 8'h90);
    stop <= 1'b1;
    repeat (h) @(posedge clk);
    stop <= 1'b0;
    wait_ev(1, p + h + 10);
    chkr(t_nmi - t0, p - 258 + h, p + 4 + h, "nmi timeout");
    chk1(irq, 1'b0, "no interval request");
    chkr(n_rst, 0, 0, "no reset in nmi mode");
    bus(1'b1, WIT_IDX_MODE, 8'h80);
    bus(1'b0, WIT_IDX_MODE, 8'h00);
    chk8(rd, 8'h90, "mode sticky");
    $display("test watchdog done");
    // reset select after a fresh reset
    rst_b <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    settle_len(17);
    bus(1'b0, WIT_IDX_MODE, 8'h00);
    chk8(rd, 8'h00, "mode after reset");
    c = n_nmi;
    bus(1'b1, WIT_IDX_MODE, 8'h98);
    wait_ev(2, 2 ** (12 - T) + 10);
    chkr(n_nmi, c, c, "no nmi in reset mode");
    $display("test reset select done");
    wrap_up();
  end
endmodule // wit_top_tb_top
